/* File: inc/charger_pkg.sv */
package charger_pkg;

    // Clock and timing
    localparam int unsigned CLK_FREQ_MHZ           = 100;
    localparam int unsigned ISOLATE_ENTRY_HOLD_US  = 1000;
    localparam int unsigned ISOLATE_EXIT_HOLD_US   = 1000;
    localparam int unsigned ISOLATE_ENTRY_CYCLES   = ISOLATE_ENTRY_HOLD_US * CLK_FREQ_MHZ;
    localparam int unsigned ISOLATE_EXIT_CYCLES    = ISOLATE_EXIT_HOLD_US * CLK_FREQ_MHZ;
    localparam int unsigned HOLD_CNT_W             = 32;

    // Register byte offsets
    localparam logic [7:0] INT_STATUS_OFFSET = 8'h00;
    localparam logic [7:0] INT_MASK_OFFSET   = 8'h04;
    localparam logic [7:0] STATE_OFFSET      = 8'h08;
    localparam logic [7:0] VARIANT_OFFSET    = 8'h0c;
    localparam int unsigned REG_ADDR_W       = 8;

    // Interrupt status / mask bit positions
    localparam int unsigned INT_W              = 6;
    localparam int unsigned INT_ISOLATE_ENTER  = 0;
    localparam int unsigned INT_ISOLATE_EXIT   = 1;
    localparam int unsigned INT_USB_GOOD       = 2;
    localparam int unsigned INT_WIRELESS_GOOD  = 3;
    localparam int unsigned INT_CHARGE_CHANGE  = 4;
    localparam int unsigned INT_CONVERTER_OFF  = 5;

    // State register bit positions
    localparam int unsigned ST_ISOLATED        = 0;
    localparam int unsigned ST_USB_GOOD        = 1;
    localparam int unsigned ST_WIRELESS_GOOD   = 2;
    localparam int unsigned ST_CHARGING        = 3;
    localparam int unsigned ST_CONVERTER_OFF   = 4;
    localparam int unsigned ST_CAP_SELECT      = 5;
    localparam int unsigned ST_LIMIT_LSB       = 6;

    // Variant register bit positions
    localparam int unsigned VAR_HAS_CAP_SELECT = 0;
    localparam int unsigned VAR_LOW_LIMIT_100  = 1;

    // Reset values
    localparam logic [INT_W-1:0] INT_MASK_RESET = 6'h00;
    localparam logic [1:0]       VARIANT_RESET  = 2'h1;

    // Bus input current limit codes
    localparam logic [1:0] LIMIT_1500MA = 2'h0;
    localparam logic [1:0] LIMIT_500MA  = 2'h1;
    localparam logic [1:0] LIMIT_100MA  = 2'h2;

    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;
    localparam logic       HRESP_OKAY    = 1'b0;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic        hready;
    } ahb_req_s;

    typedef struct packed {
        logic usb_source_ok;
        logic wireless_source_ok;
    } source_sense_s;

    typedef enum logic [1:0] {
        connected,
        entry_release,
        isolated,
        exit_release
    } isolate_state_e;

endpackage

/* File: rtl/pin_sync.sv */
`timescale 1ns/100ps
module pin_sync
    import charger_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b0
)
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic pin,
    output logic      level
);

    logic stage1;
    logic stage2;
    logic stage3;

    // Stage one is read only by stage two to keep metastability contained
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stage1 <= RESET_LEVEL;
            stage2 <= RESET_LEVEL;
            stage3 <= RESET_LEVEL;
            level  <= RESET_LEVEL;
        end
        else
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3)
                level <= stage3;
        end
    end

endmodule

/* File: rtl/charger_status_control_pins.sv */
// Behaviour
// - Interrupt low while unmasked status bits set
// - Interrupt released once all set bits read
// - Masked events never pull interrupt low
// - Long low request enters isolation, battery disconnected
// - Second long low request leaves isolation
// - Valid input source also leaves isolation
// - Charge status low while charging
// - USB good low while bus input valid
// - Wireless good only without valid bus
// - USB good forces wireless good high
// - Select pin low 1.5 A, high variant limit
// - Variants without selection ignore the pin
// - Converter off stops converter, opens input path
`timescale 1ns/100ps
module charger_status_control_pins
    import charger_pkg::*;
#(
    parameter int unsigned ENTRY_HOLD_CYCLES = ISOLATE_ENTRY_CYCLES,
    parameter int unsigned EXIT_HOLD_CYCLES  = ISOLATE_EXIT_CYCLES
)
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire ahb_req_s      bus_req,
    input  wire logic [31:0]   hwdata,
    output logic [31:0]        hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic          isolate_req_n,
    input  wire logic          input_cap_select,
    input  wire logic          converter_off,
    input  wire source_sense_s source_sense,
    input  wire logic          charge_active,
    output logic               int_n,
    output logic               stat_n,
    output logic               usb_input_good_n,
    output logic               wireless_input_good_n,
    output logic               battery_switch,
    output logic               converter_run,
    output logic               input_path_open,
    output logic [1:0]         bus_limit_code
);

    logic                   req_n_s;
    logic                   cap_sel_s;
    logic                   conv_off_s;
    logic                   usb_ok_s;
    logic                   wl_ok_s;

    isolate_state_e         state;
    isolate_state_e         next_state;
    logic [HOLD_CNT_W-1:0]  hold_cnt;
    logic [HOLD_CNT_W-1:0]  next_hold_cnt;

    logic [INT_W-1:0]       int_status;
    logic [INT_W-1:0]       int_mask;
    logic [1:0]             variant;
    logic [INT_W-1:0]       events;
    logic [INT_W-1:0]       read_clear;

    logic                   usb_good_q;
    logic                   wl_good_q;
    logic                   charging_q;
    logic                   conv_off_q;
    logic                   isolated_q;

    logic                   wr_pend;
    logic [REG_ADDR_W-1:0]  wr_addr;

    // Level inputs from the pins, all but charge_active through the same filter
    pin_sync #(.RESET_LEVEL(1'b1)) sync_req
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (isolate_req_n),
        .level   (req_n_s)
    );

    pin_sync #(.RESET_LEVEL(1'b0)) sync_cap
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (input_cap_select),
        .level   (cap_sel_s)
    );

    pin_sync #(.RESET_LEVEL(1'b0)) sync_conv
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (converter_off),
        .level   (conv_off_s)
    );

    pin_sync #(.RESET_LEVEL(1'b0)) sync_usb
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (source_sense.usb_source_ok),
        .level   (usb_ok_s)
    );

    pin_sync #(.RESET_LEVEL(1'b0)) sync_wl
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .pin     (source_sense.wireless_source_ok),
        .level   (wl_ok_s)
    );

    // Source indications
    wire usb_good      = usb_ok_s;
    wire wl_good       = wl_ok_s & ~usb_ok_s;
    wire source_valid  = usb_good | wl_good;

    // Isolation sequencer
    wire entry_done = (hold_cnt >= HOLD_CNT_W'(ENTRY_HOLD_CYCLES - 1));
    wire exit_done  = (hold_cnt >= HOLD_CNT_W'(EXIT_HOLD_CYCLES - 1));

    always_comb
    begin
        next_state    = state;
        next_hold_cnt = hold_cnt;
        unique case (state)
            connected:
            begin
                if (!req_n_s && entry_done)
                    next_state = entry_release;
            end
            entry_release:
            begin
                // The same press must end before it can count toward exit
                if (req_n_s)
                    next_state = isolated;
            end
            isolated:
            begin
                if (!req_n_s && exit_done)
                    next_state = exit_release;
            end
            exit_release:
            begin
                if (req_n_s)
                    next_state = connected;
            end
        endcase
        if (source_valid && (state == entry_release || state == isolated))
            next_state = connected;
        if (req_n_s || next_state != state)
            next_hold_cnt = '0;
        else if (!entry_done || !exit_done)
            next_hold_cnt = hold_cnt + HOLD_CNT_W'(1);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state    <= connected;
            hold_cnt <= '0;
        end
        else
        begin
            state    <= next_state;
            hold_cnt <= next_hold_cnt;
        end
    end

    wire now_isolated = (state == entry_release) || (state == isolated);

    // Current limit selection
    wire       has_sel     = variant[VAR_HAS_CAP_SELECT];
    wire [1:0] high_limit  = variant[VAR_LOW_LIMIT_100] ? LIMIT_100MA : LIMIT_500MA;
    wire [1:0] next_limit  = (has_sel && cap_sel_s) ? high_limit : LIMIT_1500MA;

    // Pin outputs, all from flops
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stat_n                <= 1'b1;
            usb_input_good_n      <= 1'b1;
            wireless_input_good_n <= 1'b1;
            battery_switch        <= 1'b1;
            converter_run         <= 1'b1;
            input_path_open       <= 1'b0;
            bus_limit_code        <= LIMIT_1500MA;
        end
        else
        begin
            stat_n                <= ~charge_active;
            usb_input_good_n      <= ~usb_good;
            wireless_input_good_n <= ~wl_good;
            battery_switch        <= ~now_isolated;
            converter_run         <= ~conv_off_s;
            input_path_open       <= conv_off_s;
            bus_limit_code        <= next_limit;
        end
    end

    // Event detection on the conditioned levels and on charge_active
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            usb_good_q <= 1'b0;
            wl_good_q  <= 1'b0;
            charging_q <= 1'b0;
            conv_off_q <= 1'b0;
            isolated_q <= 1'b0;
        end
        else
        begin
            usb_good_q <= usb_good;
            wl_good_q  <= wl_good;
            charging_q <= charge_active;
            conv_off_q <= conv_off_s;
            isolated_q <= now_isolated;
        end
    end

    always_comb
    begin
        events                    = '0;
        events[INT_ISOLATE_ENTER] = now_isolated & ~isolated_q;
        events[INT_ISOLATE_EXIT]  = ~now_isolated & isolated_q;
        events[INT_USB_GOOD]      = usb_good ^ usb_good_q;
        events[INT_WIRELESS_GOOD] = wl_good ^ wl_good_q;
        events[INT_CHARGE_CHANGE] = charge_active ^ charging_q;
        events[INT_CONVERTER_OFF] = conv_off_s ^ conv_off_q;
    end

    // Bus decode
    wire                  bus_take = bus_req.hsel && bus_req.hready
                                     && (bus_req.htrans == HTRANS_NONSEQ || bus_req.htrans == HTRANS_SEQ);
    wire [REG_ADDR_W-1:0] req_addr = bus_req.haddr[REG_ADDR_W-1:0];
    wire                  in_page  = (bus_req.haddr[31:REG_ADDR_W] == '0);
    wire                  rd_take  = bus_take && !bus_req.hwrite;
    wire                  wr_take  = bus_take && bus_req.hwrite;

    wire [31:0] state_word = {24'h000000, next_limit, cap_sel_s, conv_off_s, charge_active,
                              wl_good, usb_good, now_isolated};

    wire        sel_status = in_page && (req_addr == INT_STATUS_OFFSET);
    wire [31:0] rd_mux     = !in_page                         ? 32'h0000_0000 :
                             (req_addr == INT_STATUS_OFFSET) ? {26'h0, int_status} :
                             (req_addr == INT_MASK_OFFSET)   ? {26'h0, int_mask} :
                             (req_addr == STATE_OFFSET)      ? state_word :
                             (req_addr == VARIANT_OFFSET)    ? {30'h0, variant} :
                                                               32'h0000_0000;

    // Only the bits returned to software are cleared, so a later event survives
    assign read_clear = (rd_take && sel_status) ? int_status : '0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
            wr_pend   <= 1'b0;
            wr_addr   <= '0;
        end
        else
        begin
            if (rd_take)
                hrdata <= rd_mux;
            wr_pend <= wr_take && in_page;
            if (wr_take)
                wr_addr <= req_addr;
        end
    end

    // Register writes land in the data phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            int_mask <= INT_MASK_RESET;
            variant  <= VARIANT_RESET;
        end
        else if (wr_pend)
        begin
            if (wr_addr == INT_MASK_OFFSET)
                int_mask <= hwdata[INT_W-1:0];
            if (wr_addr == VARIANT_OFFSET)
                variant <= hwdata[1:0];
        end
    end

    // Sticky status, a new event wins over a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            int_status <= '0;
        else
            int_status <= (int_status & ~read_clear) | events;
    end

    // Masked bits still record, but never drive the pin
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            int_n <= 1'b1;
        else
            int_n <= ~|(int_status & ~int_mask);
    end

endmodule

/* File: sim/charger_pins_assertions.sv */
`timescale 1ns/100ps
module charger_pins_assertions
    import charger_pkg::*;
(
    input wire logic          hclk,
    input wire logic          hresetn,
    input wire ahb_req_s      bus_req,
    input wire logic          hreadyout,
    input wire logic          hresp,
    input wire logic          isolate_req_n,
    input wire logic          input_cap_select,
    input wire logic          converter_off,
    input wire source_sense_s source_sense,
    input wire logic          charge_active,
    input wire logic          int_n,
    input wire logic          stat_n,
    input wire logic          usb_input_good_n,
    input wire logic          wireless_input_good_n,
    input wire logic          battery_switch,
    input wire logic          converter_run,
    input wire logic          input_path_open,
    input wire logic [1:0]    bus_limit_code
);
    wire take      = bus_req.hsel & bus_req.hready & bus_req.htrans[1];
    wire rd_status = take & !bus_req.hwrite & (bus_req.haddr == {24'h0, INT_STATUS_OFFSET});
    wire wr_mask   = take & bus_req.hwrite & (bus_req.haddr == {24'h0, INT_MASK_OFFSET});

    default clocking dflt @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_stat_follow: assert property (1'b1 |=> stat_n == !$past(charge_active))
        else $error("stat_n does not follow charge_active");
    a_usb_priority: assert property (!usb_input_good_n |-> wireless_input_good_n)
        else $error("both source indicators low");
    // Only a status read or a mask write may release the interrupt
    a_int_release: assert property ($rose(int_n) |-> $past(rd_status, 2) || $past(wr_mask, 3))
        else $error("int_n rose without status read");
    a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("bus answer not ready okay");
    a_conv_off: assert property ($stable(converter_off) [*6] |->
        converter_run == !converter_off && input_path_open == converter_off)
        else $error("converter outputs wrong");
    a_limit_low: assert property (!input_cap_select [*6] |-> bus_limit_code == LIMIT_1500MA)
        else $error("low select without 1.5 A code");
    a_source_good: assert property ($stable(source_sense) [*6] |->
        usb_input_good_n == !source_sense.usb_source_ok &&
        wireless_input_good_n == !(source_sense.wireless_source_ok && !source_sense.usb_source_ok))
        else $error("source indicators wrong");
    a_entry_hold: assert property ($fell(battery_switch) |-> !$past(isolate_req_n, 20))
        else $error("isolation without long request");
endmodule

bind charger_status_control_pins charger_pins_assertions i_chk (.hclk, .hresetn, .bus_req, .hreadyout, .hresp,
    .isolate_req_n, .input_cap_select, .converter_off, .source_sense, .charge_active, .int_n, .stat_n,
    .usb_input_good_n, .wireless_input_good_n, .battery_switch, .converter_run, .input_path_open, .bus_limit_code);

/* File: sim/board_straps.sv */
`timescale 1ns/100ps
module board_straps
(
    input  wire logic hclk,
    output logic      isolate_req_n,
    output logic      input_cap_select,
    output logic      converter_off
);
    // Request pulled up, select and disable pulled down when idle
    initial
    begin
        isolate_req_n    = 1'b1;
        input_cap_select = 1'b0;
        converter_off    = 1'b0;
    end

    task press(input int n);
        isolate_req_n <= 1'b0;
        repeat (n) @(posedge hclk);
        isolate_req_n <= 1'b1;
    endtask

    task strap(input logic cap, input logic off);
        input_cap_select <= cap;
        converter_off    <= off;
    endtask
endmodule

/* File: sim/charger_status_control_pins_tb.sv */
`timescale 1ns/100ps
module charger_status_control_pins_tb
    import charger_pkg::*;
;
    logic          hclk;
    logic          hresetn;
    logic          sel;
    logic [31:0]   adr;
    logic [1:0]    trn;
    logic          wr;
    logic [2:0]    siz;
    logic [31:0]   hwdata;
    logic          charge_active;
    source_sense_s source_sense;
    logic [31:0]   d;
    int            errors = 0;
    int            n_tests = 0;
    int            cycles = 0;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, int_n, stat_n, usb_input_good_n, wireless_input_good_n;
    wire logic battery_switch, converter_run, input_path_open;
    wire logic [1:0] bus_limit_code;
    wire logic isolate_req_n, input_cap_select, converter_off;
    wire ahb_req_s bus_req = {sel, adr, trn, wr, siz, hreadyout};

    always #5 hclk = ~hclk;

    board_straps i_board (.hclk, .isolate_req_n, .input_cap_select, .converter_off);

    // Short hold counts keep the isolation presses brief
    charger_status_control_pins #(.ENTRY_HOLD_CYCLES(20), .EXIT_HOLD_CYCLES(20)) i_dut (.hclk, .hresetn,
        .bus_req, .hwdata, .hrdata, .hreadyout, .hresp, .isolate_req_n, .input_cap_select, .converter_off,
        .source_sense, .charge_active, .int_n, .stat_n, .usb_input_good_n, .wireless_input_good_n,
        .battery_switch, .converter_run, .input_path_open, .bus_limit_code);

    task give_verdict;
        $display("mismatches %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        sel <= 1'b1;
        adr <= {24'h0, a};
        trn <= HTRANS_NONSEQ;
        wr  <= w;
        siz <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        sel    <= 1'b0;
        trn    <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        d = hrdata;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(d & m, e);
    endtask

    // Let the edge's updates land before looking
    task cyc(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            errors++;
            give_verdict();
        end
    end

    initial
    begin
        hclk          = 1'b0;
        hresetn       = 1'b0;
        sel           = 1'b0;
        adr           = 32'h0;
        trn           = 2'h0;
        wr            = 1'b0;
        siz           = 3'h2;
        hwdata        = 32'h0;
        charge_active = 1'b0;
        source_sense  = '0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        cyc(1);
        chk({24'h0, int_n, stat_n, usb_input_good_n, wireless_input_good_n, battery_switch, converter_run,
            input_path_open, hresp}, 32'hfc);
        rdchk(INT_MASK_OFFSET, 32'hffffffff, {26'h0, INT_MASK_RESET});
        rdchk(VARIANT_OFFSET, 32'hffffffff, {30'h0, VARIANT_RESET});
        rdchk(8'h10, 32'hffffffff, 32'h0);
        xfer(1'b1, INT_STATUS_OFFSET, 32'h3f);
        rdchk(INT_STATUS_OFFSET, 32'hffffffff, 32'h0);
        charge_active <= 1'b1;
        cyc(4);
        chkb(stat_n, 1'b0);
        chkb(int_n, 1'b0);
        rdchk(INT_STATUS_OFFSET, 32'hffffffff, 32'h10);
        cyc(2);
        chkb(int_n, 1'b1);
        rdchk(INT_STATUS_OFFSET, 32'hffffffff, 32'h0);
        xfer(1'b1, INT_MASK_OFFSET, 32'h10);
        rdchk(INT_MASK_OFFSET, 32'hffffffff, 32'h10);
        charge_active <= 1'b0;
        cyc(4);
        chkb(int_n, 1'b1);
        chkb(stat_n, 1'b1);
        rdchk(INT_STATUS_OFFSET, 32'hffffffff, 32'h10);
        xfer(1'b1, INT_MASK_OFFSET, 32'h0);
        i_board.press(15);
        cyc(5);
        i_board.press(15);
        cyc(10);
        chkb(battery_switch, 1'b1);
        i_board.press(30);
        cyc(10);
        chkb(battery_switch, 1'b0);
        chkb(int_n, 1'b0);
        rdchk(STATE_OFFSET, 32'h1, 32'h1);
        rdchk(INT_STATUS_OFFSET, 32'h1, 32'h1);
        i_board.press(30);
        cyc(10);
        chkb(battery_switch, 1'b1);
        rdchk(INT_STATUS_OFFSET, 32'h2, 32'h2);
        i_board.press(30);
        cyc(10);
        chkb(battery_switch, 1'b0);
        source_sense <= 2'b11;
        cyc(8);
        chkb(battery_switch, 1'b1);
        chkb(usb_input_good_n, 1'b0);
        chkb(wireless_input_good_n, 1'b1);
        source_sense <= 2'b01;
        cyc(8);
        chkb(usb_input_good_n, 1'b1);
        chkb(wireless_input_good_n, 1'b0);
        source_sense <= 2'b00;
        i_board.strap(1'b1, 1'b0);
        cyc(8);
        chk({30'h0, bus_limit_code}, {30'h0, LIMIT_500MA});
        xfer(1'b1, VARIANT_OFFSET, 32'h3);
        cyc(3);
        chk({30'h0, bus_limit_code}, {30'h0, LIMIT_100MA});
        xfer(1'b1, VARIANT_OFFSET, 32'h0);
        cyc(3);
        chk({30'h0, bus_limit_code}, {30'h0, LIMIT_1500MA});
        i_board.strap(1'b0, 1'b1);
        cyc(8);
        chkb(converter_run, 1'b0);
        chkb(input_path_open, 1'b1);
        rdchk(INT_STATUS_OFFSET, 32'h20, 32'h20);
        i_board.strap(1'b0, 1'b0);
        cyc(8);
        chkb(converter_run, 1'b1);
        give_verdict();
    end
endmodule
